// ==== verilog/lhc_core.sv ====
// Purpose: heater enable decision, diagnostics, filtering and output select
// Assumes: sense inputs synchronous to clk, analog levels already digitised
// Notes: registers on a plain strobe port, read data one cycle after rd
`include "lhc_regs.svh"
`timescale 1ns/10ps
`default_nettype none
// Operation
// R1: active and supply ok enables heater
// R2: supply out of range disables heater
// R3: mode is master when off/standby
// R4: external mode follows external signal
// R5: external on at 9V, off at 2V
// R6: between thresholds hold previous state
// R7: mode ignored in active state
// R8: heater curve ramps power to temperature
// R9: flag resistance deviation beyond ten percent
// R10: report supply, low supply is control error
// R11: fuse open control error, shorts flagged
// R12: cable identification gives sensor type status
// R13: all seven quantities available together
// R14: one quantity to analog, never resistance
// R15: configurable iir cutoff smooths signal
// R16: one filter setting for all outputs
// R17: per channel lower and upper range limits
// R18: monitor, drive led, report diagnosis
// R19: integrity error sticks until reload
// R20: self-test inconsistency sets plausibility error
// R21: report detected external enable level
// R22: no measure values when off/standby
module lhc_core (
   input wire logic clk,
   input wire logic sys_rst,
   input wire lhc_pkg::lhc_bus_req_t bus,
   output logic [15:0] rdata,
   input wire logic [15:0] ext_enable_mv,
   input wire lhc_pkg::lhc_sense_t sense,
   input wire lhc_pkg::lhc_meas_t meas_raw,
   input wire logic [15:0] sensor_temp_c,
   output logic heater_en,
   output logic [7:0] heater_power,
   output logic [15:0] analog_out,
   output logic status_led,
   output var lhc_pkg::lhc_meas_t meas_out,
   output logic meas_valid
);
   import lhc_pkg::*;

   logic [15:0] ctrl_q;
   logic [2:0] aout_sel_q;
   logic [3:0] filt_q;
   logic [15:0] rng_lo_q [0:6];
   logic [15:0] rng_hi_q [0:6];
   logic ext_on_q;
   logic heat_d;
   logic heat_q;
   logic [7:0] power_q;
   logic ri_dev;
   logic [6:0] diag_q;
   logic integ_q;
   logic plaus_q;
   logic [15:0] filt_val [0:6];
   logic [15:0] raw_val [0:6];
   logic [15:0] rdata_d;
   logic [15:0] ri_tol;
   logic meas_en;
   lhc_heat_mode_t mode;
   lhc_opstate_t opst;
   logic wr_ctrl;
   logic wr_aout_sel;
   logic wr_filt;
   logic rng_hit;
   logic meas_hit;

   assign mode = lhc_heat_mode_t'(ctrl_q[`LHC_CTRL_MODE_LSB +: 2]);
   assign opst = lhc_opstate_t'(ctrl_q[`LHC_CTRL_OPST_LSB +: 2]);
   assign meas_en = (opst == LHC_OP_ON);

   // write decode; read-only and unmapped indices match nothing here
   assign wr_ctrl = bus.wr && (bus.addr == `LHC_REG_CTRL);
   assign wr_aout_sel = bus.wr && (bus.addr == `LHC_REG_AOUT_SEL);
   assign wr_filt = bus.wr && (bus.addr == `LHC_REG_FILT);
   assign rng_hit = (bus.addr[7:4] == 4'(`LHC_REG_RANGE_BASE >> 4)) &&
                    (bus.addr[3:1] < 3'(`LHC_NUM_MEAS));
   assign meas_hit = (bus.addr[7:4] == 4'(`LHC_REG_MEAS_BASE >> 4)) &&
                     (bus.addr[3:0] < 4'(`LHC_NUM_MEAS));

   // operating state and heating mode
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ctrl_q <= `LHC_CTRL_RST;
      end else if (wr_ctrl) begin
         ctrl_q <= bus.wdata;
      end
   end

   // R14: resistance not selectable
   // a refused select keeps the old choice, so the output never jumps
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         aout_sel_q <= `LHC_AOUT_RST;
      end else if (wr_aout_sel && (bus.wdata[2:0] < `LHC_RI_IDX)) begin
         aout_sel_q <= bus.wdata[2:0];
      end
   end

   // R16: single filter setting
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         filt_q <= `LHC_FILT_RST;
      end else if (wr_filt) begin
         filt_q <= bus.wdata[3:0];
      end
   end

   // R17: range limit storage
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         for (int i = 0; i < `LHC_NUM_MEAS; i++) begin
            rng_lo_q[i] <= 16'h0000;
            rng_hi_q[i] <= 16'hffff;
         end
      end else if (bus.wr && rng_hit) begin
         if (bus.addr[0]) begin
            rng_hi_q[bus.addr[3:1]] <= bus.wdata;
         end else begin
            rng_lo_q[bus.addr[3:1]] <= bus.wdata;
         end
      end
   end

   // R5: threshold detection
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ext_on_q <= 1'b0;
      end else if (ext_enable_mv >= `LHC_EXT_ON_MV) begin
         ext_on_q <= 1'b1;
      end else if (ext_enable_mv <= `LHC_EXT_OFF_MV) begin
         ext_on_q <= 1'b0;
      end
      // R6: hysteresis band holds
   end

   always_comb begin
      heat_d = 1'b0;
      if (!sense.supply_ok) begin
         // R2: supply out of range
         heat_d = 1'b0;
      end else if (opst == LHC_OP_ON) begin
         // R1: active always heats
         // R7: mode ignored here
         heat_d = 1'b1;
      end else begin
         // R3: mode as master
         case (mode)
            LHC_HM_OFF: heat_d = 1'b0;
            LHC_HM_ON: heat_d = 1'b1;
            // R4: follow external signal
            LHC_HM_EXT: heat_d = ext_on_q;
            default: heat_d = 1'b0;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         heat_q <= 1'b0;
      end else begin
         heat_q <= heat_d;
      end
   end

   // R8: ramp power until working temperature
   // stand-in curve: one step a clock, held at full scale
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         power_q <= 8'h00;
      end else if (!heat_q) begin
         power_q <= 8'h00;
      end else if (sensor_temp_c >= `LHC_WORK_TEMP_C) begin
         power_q <= 8'h00;
      end else if (power_q != 8'hff) begin
         power_q <= power_q + 8'h01;
      end
   end

   // R9: tolerance band around nominal
   // a reading exactly on a band edge still counts as in tolerance
   assign ri_tol = 16'((32'(`LHC_NOMINAL_INTERNAL_RESISTANCE_OHM) * 32'(`LHC_RI_TOL_PCT)) / 32'd100);
   assign ri_dev = (meas_raw.sensor_internal_resistance > `LHC_NOMINAL_INTERNAL_RESISTANCE_OHM + ri_tol) ||
                   (meas_raw.sensor_internal_resistance < `LHC_NOMINAL_INTERNAL_RESISTANCE_OHM - ri_tol);

   // R19: integrity error sticks until reset by reload
   // only reset, which stands for a firmware reload, clears it
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         integ_q <= 1'b0;
      end else if (sense.integ_fail) begin
         integ_q <= 1'b1;
      end
   end

   // R20: self-test plausibility error
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         plaus_q <= 1'b0;
      end else if (sense.selftest_bad) begin
         plaus_q <= 1'b1;
      end
   end

   // R18: continuous diagnosis
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         diag_q <= 7'h00;
      end else begin
         diag_q[`LHC_DG_RI] <= ri_dev && heat_q;
         // R10: low supply or R11: blown fuse
         diag_q[`LHC_DG_LCTRL] <= sense.supply_low || sense.fuse_open;
         // R11: cable and connector shorts
         diag_q[`LHC_DG_SHORT] <= sense.cable_short;
         // R12: wrong sensor type from cable id
         diag_q[`LHC_DG_TYPE] <= !sense.type_ok;
         diag_q[`LHC_DG_SUPPLY] <= !sense.supply_ok;
         diag_q[`LHC_DG_INTEG] <= integ_q || sense.integ_fail;
         diag_q[`LHC_DG_PLAUS] <= plaus_q || sense.selftest_bad;
      end
   end

   // R18: led lights on any deviation
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         status_led <= 1'b0;
      end else begin
         status_led <= (diag_q != 7'h00) ? `LHC_LED_ON : ~`LHC_LED_ON;
      end
   end

   assign raw_val[0] = meas_raw.lambda;
   assign raw_val[1] = meas_raw.inv_lambda;
   assign raw_val[2] = meas_raw.air_fuel;
   assign raw_val[3] = meas_raw.fuel_air;
   assign raw_val[4] = meas_raw.o2;
   assign raw_val[5] = meas_raw.sensor_pump_current;
   assign raw_val[6] = meas_raw.sensor_internal_resistance;

   // R15: per-quantity iir smoothing
   generate
      for (genvar g = 0; g < `LHC_NUM_MEAS; g++) begin : g_filt
         lhc_iir u_iir (
            .clk(clk),
            .sys_rst(sys_rst),
            .en(meas_en),
            .shift(filt_q),
            .din(raw_val[g]),
            .dout(filt_val[g])
         );
      end
   endgenerate

   // R13: all quantities at once
   // R22: nothing while off or standby
   always_ff @(posedge clk) begin
      if (sys_rst || !meas_en) begin
         meas_out <= '0;
      end else begin
         meas_out <= {filt_val[6], filt_val[5], filt_val[4], filt_val[3],
                      filt_val[2], filt_val[1], filt_val[0]};
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         meas_valid <= 1'b0;
      end else begin
         meas_valid <= meas_en;
      end
   end

   // R14: analog selection
   // zero rather than a stale value when idle, so a scope sees the stop
   always_ff @(posedge clk) begin
      if (sys_rst || !meas_en) begin
         analog_out <= 16'h0000;
      end else begin
         analog_out <= filt_val[aout_sel_q];
      end
   end

   always_comb begin
      rdata_d = 16'h0000;
      case (bus.addr)
         `LHC_REG_CTRL: rdata_d = ctrl_q;
         `LHC_REG_AOUT_SEL: rdata_d = {13'h0000, aout_sel_q};
         `LHC_REG_FILT: rdata_d = {12'h000, filt_q};
         // R21: report detected external level
         `LHC_REG_STATUS: rdata_d = {11'h000, meas_en, sense.type_ok,
                                     sense.supply_ok, ext_on_q, heat_q};
         `LHC_REG_DIAG: rdata_d = {9'h000, diag_q};
         `LHC_REG_AOUT: rdata_d = analog_out;
         `LHC_REG_HEAT_PWR: rdata_d = {8'h00, power_q};
         `LHC_REG_NOM_RI: rdata_d = `LHC_NOMINAL_INTERNAL_RESISTANCE_OHM;
         `LHC_REG_REF_IP: rdata_d = 16'h0000;
         default: begin
            if (rng_hit) begin
               rdata_d = bus.addr[0] ? rng_hi_q[bus.addr[3:1]] : rng_lo_q[bus.addr[3:1]];
            end else if (meas_hit && meas_en) begin
               // R22: measure words read zero outside the active state
               rdata_d = filt_val[bus.addr[2:0]];
            end
         end
      endcase
   end

   // back to zero after one cycle so a stale word is never taken as a reply
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         rdata <= 16'h0000;
      end else if (bus.rd) begin
         rdata <= rdata_d;
      end else begin
         rdata <= 16'h0000;
      end
   end

   // registered again so the pins never glitch with the decision logic
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         heater_en <= 1'b0;
      end else begin
         heater_en <= heat_q;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         heater_power <= 8'h00;
      end else begin
         heater_power <= power_q;
      end
   end
endmodule // lhc_core
`default_nettype wire

// ==== verilog/lhc_regs.svh ====
// Purpose: register offsets, field positions, reset values and constants for lhc
// Assumes: word-addressed 8-bit register index, 16-bit data
// Notes: definitions only
`ifndef LHC_REGS_SVH
`define LHC_REGS_SVH

`define LHC_REG_CTRL 8'h00
`define LHC_REG_AOUT_SEL 8'h01
`define LHC_REG_FILT 8'h02
`define LHC_REG_RANGE_BASE 8'h10
`define LHC_REG_STATUS 8'h20
`define LHC_REG_DIAG 8'h21
`define LHC_REG_AOUT 8'h22
`define LHC_REG_HEAT_PWR 8'h23
`define LHC_REG_MEAS_BASE 8'h30
`define LHC_REG_NOM_RI 8'h40
`define LHC_REG_REF_IP 8'h41

// ctrl fields
`define LHC_CTRL_MODE_LSB 0
`define LHC_CTRL_OPST_LSB 2
`define LHC_CTRL_RST 16'h0000

// status bits
`define LHC_ST_HEAT 0
`define LHC_ST_EXT 1
`define LHC_ST_SUPPLY 2
`define LHC_ST_TYPE 3
`define LHC_ST_MEASV 4

// diag bits
`define LHC_DG_RI 0
`define LHC_DG_LCTRL 1
`define LHC_DG_SHORT 2
`define LHC_DG_TYPE 3
`define LHC_DG_SUPPLY 4
`define LHC_DG_INTEG 5
`define LHC_DG_PLAUS 6

// external enable thresholds in millivolts
`define LHC_EXT_ON_MV 16'd9000
`define LHC_EXT_OFF_MV 16'd2000

// internal resistance nominal and tolerance
`define LHC_NOMINAL_INTERNAL_RESISTANCE_OHM 16'd300
`define LHC_RI_TOL_PCT 16'd10

`define LHC_WORK_TEMP_C 16'd780
`define LHC_FILT_RST 4'h4
`define LHC_NUM_MEAS 7
`define LHC_AOUT_RST 3'h0
`define LHC_RI_IDX 3'h6
`define LHC_LED_ON 1'b1

`endif

// ==== verilog/lhc_pkg.sv ====
// Purpose: types for the heater control and diagnostic block
// Assumes: lhc_regs.svh for constants
// Notes: none
`default_nettype none
package lhc_pkg;
   typedef enum logic [1:0] {LHC_HM_OFF, LHC_HM_ON, LHC_HM_EXT, LHC_HM_RSV} lhc_heat_mode_t;
   typedef enum logic [1:0] {LHC_OP_OFF, LHC_OP_STANDBY, LHC_OP_ON, LHC_OP_RSV} lhc_opstate_t;
   typedef struct packed {
      logic [7:0] addr;
      logic [15:0] wdata;
      logic wr;
      logic rd;
   } lhc_bus_req_t;
   typedef struct packed {
      logic supply_ok;
      logic supply_low;
      logic fuse_open;
      logic cable_short;
      logic type_ok;
      logic integ_fail;
      logic selftest_bad;
   } lhc_sense_t;
   typedef struct packed {
      logic [15:0] sensor_internal_resistance;
      logic [15:0] sensor_pump_current;
      logic [15:0] o2;
      logic [15:0] fuel_air;
      logic [15:0] air_fuel;
      logic [15:0] inv_lambda;
      logic [15:0] lambda;
   } lhc_meas_t;
endpackage
`default_nettype wire

// ==== verilog/lhc_iir.sv ====
// Purpose: first-order iir smoother, one per quantity
// Assumes: new sample every clock while enabled
// Notes: shift k sets cutoff; larger k smooths more
`timescale 1ns/10ps
`default_nettype none
module lhc_iir (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic en,
   input wire logic [3:0] shift,
   input wire logic [15:0] din,
   output logic [15:0] dout
);
   logic [31:0] acc_q;
   logic [31:0] acc_d;
   logic signed [32:0] diff;

   always_comb begin
      diff = $signed({1'b0, din, 16'h0000}) - $signed({1'b0, acc_q});
      acc_d = acc_q + 32'(diff >>> shift);
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         acc_q <= 32'h0000_0000;
      end else if (en) begin
         acc_q <= acc_d;
      end
   end

   assign dout = acc_q[31:16];
endmodule // lhc_iir
`default_nettype wire

// ==== testbench/lhc_sensor_model.sv ====
// Purpose: oxygen sensor, heater and cable seen from the control block
// Assumes: bench sets faults, level and resistance; heater warms element
// Notes: measured quantities other than resistance sit at fixed offsets from one level
`timescale 1ns/10ps
`default_nettype none
module lhc_sensor_model (
   input wire logic clk,
   input wire logic heater_en,
   input wire lhc_pkg::lhc_sense_t cfg,
   input wire logic [15:0] lvl,
   input wire logic [15:0] ri_ohm,
   output var lhc_pkg::lhc_sense_t sense,
   output var lhc_pkg::lhc_meas_t meas_raw,
   output logic [15:0] sensor_temp_c
);
   import lhc_pkg::*;
   assign sense = cfg;
   assign meas_raw = {ri_ohm, lvl + 16'h0500, lvl + 16'h0400, lvl + 16'h0300,
      lvl + 16'h0200, lvl + 16'h0100, lvl};
   initial sensor_temp_c = 16'h0014;
   // element warms while heated and cools to ambient otherwise
   always @(posedge clk) begin
      if (heater_en && sensor_temp_c < 16'h0384) begin
         sensor_temp_c <= sensor_temp_c + 16'h0001;
      end else if (sensor_temp_c > 16'h0014) begin
         sensor_temp_c <= sensor_temp_c - 16'h0001;
      end
   end
endmodule // lhc_sensor_model
`default_nettype wire

// ==== testbench/lhc_core_checker.sv ====
// Purpose: port-level properties of the heater control block
// Assumes: one clock domain, sync reset
// Notes: margins of two to three cycles cover the registered heater path
`timescale 1ns/10ps
`default_nettype none
module lhc_core_checker (
   input wire logic clk,
   input wire logic sys_rst,
   input wire lhc_pkg::lhc_bus_req_t bus,
   input wire logic [15:0] rdata,
   input wire lhc_pkg::lhc_sense_t sense,
   input wire lhc_pkg::lhc_meas_t meas_raw,
   input wire logic [15:0] sensor_temp_c,
   input wire logic heater_en,
   input wire logic [7:0] heater_power,
   input wire logic [15:0] analog_out,
   input wire logic status_led,
   input wire lhc_pkg::lhc_meas_t meas_out,
   input wire logic meas_valid
);
   import lhc_pkg::*;
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   sequence s_warming;
      (heater_en && sensor_temp_c < 16'h030c) [*3];
   endsequence
   sequence s_active_ok;
      (meas_valid && sense.supply_ok) [*3];
   endsequence
   supply_cut_a:
      assert property (!sense.supply_ok [*3] |-> !heater_en) else $error("heater on, bad supply");
   active_heat_a:
      assert property (s_active_ok |-> heater_en) else $error("active but heater off");
   power_idle_a:
      assert property (!heater_en [*2] |-> heater_power == 8'h00) else $error("power while off");
   warm_ramp_a:
      assert property (s_warming |-> heater_power != 8'h00) else $error("no power while cold");
   hot_stop_a:
      assert property ((sensor_temp_c >= 16'h030c) [*3] |-> heater_power == 8'h00)
         else $error("power at working temperature");
   no_meas_a:
      assert property (!meas_valid [*2] |-> meas_out == '0 && analog_out == 16'h0000)
         else $error("values while not measuring");
   fuse_led_a:
      assert property (sense.fuse_open [*3] |-> status_led) else $error("fuse fault not shown");
   integ_hold_a:
      assert property ($rose(sense.integ_fail) |-> ##3 status_led [*6])
         else $error("integrity error not held");
   ri_flag_a:
      assert property ((heater_en && meas_raw.sensor_internal_resistance > 16'h014a) [*3]
         |-> status_led) else $error("resistance deviation not shown");
   rdata_idle_a:
      assert property ($past(bus.rd) == 1'b0 |-> rdata == 16'h0000) else $error("stray rdata");
endmodule // lhc_core_checker
bind lhc_core lhc_core_checker u_chk (.clk(clk), .sys_rst(sys_rst), .bus(bus), .rdata(rdata),
   .sense(sense), .meas_raw(meas_raw), .sensor_temp_c(sensor_temp_c), .heater_en(heater_en),
   .heater_power(heater_power), .analog_out(analog_out), .status_led(status_led),
   .meas_out(meas_out), .meas_valid(meas_valid));
`default_nettype wire

// ==== testbench/lhc_core_tb_top.sv ====
// Purpose: self-checking bench for the heater control block
// Assumes: sensor model on the far side, registers on the strobe port
// Notes: diagnostics run last since two of them stay set
`timescale 1ns/10ps
`default_nettype none
module lhc_core_tb_top;
   import lhc_pkg::*;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   lhc_bus_req_t bus = '0;
   lhc_sense_t cfg = 7'h44;
   logic [15:0] ext_mv = 16'h0000;
   logic [15:0] lvl = 16'h1000;
   logic [15:0] ri = 16'h012c;
   logic [15:0] rdata, analog_out, temp;
   logic heater_en, status_led, meas_valid;
   logic [7:0] heater_power;
   lhc_sense_t sense;
   lhc_meas_t meas_raw, meas_out;
   int miscompares = 0;
   int compares = 0;
   int cyc = 0;
   lhc_core DUT (.clk(clk), .sys_rst(sys_rst), .bus(bus), .rdata(rdata),
      .ext_enable_mv(ext_mv), .sense(sense), .meas_raw(meas_raw), .sensor_temp_c(temp),
      .heater_en(heater_en), .heater_power(heater_power), .analog_out(analog_out),
      .status_led(status_led), .meas_out(meas_out), .meas_valid(meas_valid));
   lhc_sensor_model u_sns (.clk(clk), .heater_en(heater_en), .cfg(cfg), .lvl(lvl),
      .ri_ohm(ri), .sense(sense), .meas_raw(meas_raw), .sensor_temp_c(temp));
   initial begin
      forever #25 clk = ~clk;
   end
   task automatic results;
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   // a hang ends the run as a failure
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         miscompares = miscompares + 1;
         results();
      end
   end
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         miscompares++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk);
      bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk);
      bus.wr <= 1'b0;
   endtask
   task automatic rchk(input logic [7:0] a, input logic [15:0] e);
      @(posedge clk);
      bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
      @(posedge clk);
      bus.rd <= 1'b0;
      #1 chk(rdata, e);
   endtask
   task automatic regs;
      rchk(8'h00, 16'h0000);
      rchk(8'h02, 16'h0004);
      rchk(8'h10, 16'h0000);
      rchk(8'h11, 16'hffff);
      wr(8'h1d, 16'h1234);
      rchk(8'h1d, 16'h1234);
      rchk(8'h40, 16'h012c);
      wr(8'h20, 16'hffff);
      rchk(8'h55, 16'h0000);
   endtask
   // c is {state, mode}; eh heater expected, ee detected external level
   task automatic heat(input logic [3:0] c, input logic [15:0] mv, input logic ok,
      input logic eh, input logic ee);
      wr(8'h00, {12'h000, c});
      cfg.supply_ok <= ok;
      ext_mv <= mv;
      repeat (5) @(posedge clk);
      #1 chk({15'h0000, heater_en}, {15'h0000, eh});
      rchk(8'h20, {11'h000, c[3], 1'h1, ok, ee, eh});
   endtask
   task automatic curve;
      int n;
      wr(8'h00, 16'h0008);
      cfg <= 7'h44;
      repeat (4) @(posedge clk);
      #1 chk({15'h0000, heater_power != 8'h00}, 16'h0001);
      n = 0;
      while (temp < 16'h030c && n < 2000) begin
         @(posedge clk);
         n++;
      end
      repeat (3) @(posedge clk);
      #1 chk({8'h00, heater_power}, 16'h0000);
   endtask
   task automatic meas;
      wr(8'h00, 16'h0000);
      wr(8'h02, 16'h0000);
      repeat (3) @(posedge clk);
      rchk(8'h30, 16'h0000);
      wr(8'h00, 16'h0008);
      repeat (4) @(posedge clk);
      for (int i = 0; i < 7; i++) begin
         rchk(8'h30 + 8'(i), i < 6 ? lvl + {8'(i), 8'h00} : ri);
      end
      // a select of the resistance is refused and the last choice stays
      for (int i = 0; i < 7; i++) begin
         wr(8'h01, 16'(i));
         repeat (3) @(posedge clk);
         #1 chk(analog_out, lvl + {8'(i < 6 ? i : 5), 8'h00});
      end
      wr(8'h01, 16'h0000);
      wr(8'h02, 16'h0004);
      lvl <= 16'h2000;
      repeat (3) @(posedge clk);
      #1 chk({15'h0000, analog_out < 16'h1800}, 16'h0001);
      chk({15'h0000, meas_out.inv_lambda < 16'h1900}, 16'h0001);
      repeat (400) @(posedge clk);
      #1 chk({15'h0000, 16'h2000 - analog_out < 16'h0020}, 16'h0001);
      wr(8'h00, 16'h0000);
      repeat (3) @(posedge clk);
      #1 chk({15'h0000, meas_valid}, 16'h0000);
      wr(8'h00, 16'h0008);
   endtask
   task automatic diag(input lhc_sense_t f, input logic [15:0] r, input logic [15:0] e);
      @(posedge clk);
      cfg <= f;
      ri <= r;
      repeat (5) @(posedge clk);
      rchk(8'h21, e);
      chk({15'h0000, status_led}, {15'h0000, e != 16'h0000});
   endtask
   initial begin
      repeat (20) @(posedge clk);
      sys_rst <= 1'b0;
      regs();
      heat(4'h8, 16'h0000, 1'h1, 1'h1, 1'h0);
      heat(4'h0, 16'h2328, 1'h1, 1'h0, 1'h1);
      heat(4'h5, 16'h0000, 1'h1, 1'h1, 1'h0);
      heat(4'h2, 16'h2328, 1'h1, 1'h1, 1'h1);
      heat(4'h6, 16'h1388, 1'h1, 1'h1, 1'h1);
      heat(4'h2, 16'h07d0, 1'h1, 1'h0, 1'h0);
      heat(4'h6, 16'h2327, 1'h1, 1'h0, 1'h0);
      heat(4'ha, 16'h2328, 1'h0, 1'h0, 1'h1);
      heat(4'h5, 16'h0000, 1'h0, 1'h0, 1'h0);
      curve();
      meas();
      diag(7'h44, 16'h014a, 16'h0000);
      diag(7'h44, 16'h0154, 16'h0001);
      diag(7'h44, 16'h010d, 16'h0001);
      diag(7'h54, 16'h012c, 16'h0002);
      diag(7'h4c, 16'h012c, 16'h0004);
      diag(7'h40, 16'h012c, 16'h0008);
      diag(7'h64, 16'h012c, 16'h0002);
      diag(7'h04, 16'h012c, 16'h0010);
      diag(7'h46, 16'h012c, 16'h0020);
      diag(7'h45, 16'h012c, 16'h0060);
      diag(7'h44, 16'h012c, 16'h0060);
      results();
   end
endmodule // lhc_core_tb_top
`default_nettype wire
